// ---- hw/cise_cfg.svh ----
// Constants for the instruction subset execution block.
`ifndef CISE_CFG_SVH
`define CISE_CFG_SVH
// Opcode field layout (14-bit instruction word).
`define CISE_OP_W 14
`define CISE_F_W 7
`define CISE_PC_W 15
// Fixed encodings for opcodes without operands.
`define CISE_OPC_ACC_CALL 14'h000a
`define CISE_OPC_ACC_CLR 14'h0100
`define CISE_OPC_WDOG_CLR 14'h0064
// Masked encodings: upper bits select the operation.
`define CISE_MSK_BTSS 4'hb
`define CISE_MSK_CALL 3'h4
`define CISE_MSK_FILE_CLR 7'h03
`define CISE_MSK_FILE_CPL 6'h09
// Reset values.
`define CISE_PC_RST 15'h0000
`define CISE_ZERO8 8'h00
`define CISE_WDT_RST 16'h0000
`define CISE_PRE_RST 8'h00
`endif

// ---- hw/cise_pkg.sv ----
// Types shared by the instruction subset execution block.
package cise_pkg;
  // Decoded operation class.
  typedef enum logic [3:0] {
    CISE_OP_NOP = 4'h0,
    CISE_OP_BTSS = 4'h1,
    CISE_OP_CALL = 4'h2,
    CISE_OP_ACC_CALL = 4'h3,
    CISE_OP_FILE_CLR = 4'h4,
    CISE_OP_ACC_CLR = 4'h5,
    CISE_OP_WDOG_CLR = 4'h6,
    CISE_OP_FILE_CPL = 4'h7
  } cise_op_t;
  // Execution sequencer state.
  typedef enum logic [1:0] {
    CISE_ST_RUN = 2'b00,
    CISE_ST_FLUSH = 2'b01
  } cise_state_t;
endpackage

// ---- hw/cise_dec_if.sv ----
// Interface carrying a decoded instruction from decoder to executor.
interface cise_dec_if;
  import cise_pkg::*;
  cise_op_t op;
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic dsel;
  logic [10:0] kimm;
  modport dec (output op, output faddr, output bsel, output dsel, output kimm);
  modport exe (input op, input faddr, input bsel, input dsel, input kimm);
endinterface

// ---- hw/cise_decode.sv ----
// Combinational decoder of the supported instruction subset.
`include "cise_cfg.svh"
module cise_decode (
  // Instruction word.
  input wire logic [13:0] i_instr,
  // Decoded fields.
  cise_dec_if.dec dec
);
  import cise_pkg::*;

  // --------------------------------------------------------------
  // Opcode match
  // --------------------------------------------------------------
  // Exact opcodes are tested first so masked classes cannot shadow them.
  always_comb begin
    dec.faddr = i_instr[6:0];
    dec.bsel = i_instr[9:7];
    dec.dsel = i_instr[7];
    dec.kimm = i_instr[10:0];
    if (i_instr == `CISE_OPC_ACC_CALL) begin
      dec.op = CISE_OP_ACC_CALL;
    end else if (i_instr == `CISE_OPC_WDOG_CLR) begin
      dec.op = CISE_OP_WDOG_CLR;
    end else if (i_instr[13:2] == 12'(`CISE_OPC_ACC_CLR >> 2)) begin
      // Low two bits of this opcode are don't-care.
      dec.op = CISE_OP_ACC_CLR;
    end else if (i_instr[13:10] == `CISE_MSK_BTSS) begin
      dec.op = CISE_OP_BTSS;
    end else if (i_instr[13:11] == `CISE_MSK_CALL) begin
      dec.op = CISE_OP_CALL;
    end else if (i_instr[13:7] == `CISE_MSK_FILE_CLR) begin
      dec.op = CISE_OP_FILE_CLR;
    end else if (i_instr[13:8] == `CISE_MSK_FILE_CPL) begin
      dec.op = CISE_OP_FILE_CPL;
    end else begin
      // Anything outside the subset executes as a no-operation here.
      dec.op = CISE_OP_NOP;
    end
  end
endmodule

// ---- hw/cise_core.sv ----
// Execution unit for a subset of an 8-bit core's instructions.
`include "cise_cfg.svh"
module cise_core (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Instruction stream.
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  // File register read port (value at i_instr's address).
  input wire logic [7:0] i_file_rdata,
  // Program counter latch high register value.
  input wire logic [6:0] i_program_counter_latch_high,
  // Watchdog tick from the prescaler input clock enable.
  input wire logic i_wdt_tick,
  // Program counter and stack push.
  output logic [14:0] o_program_counter,
  output logic o_stack_push,
  output logic [14:0] o_return_stack_top,
  // File register write port.
  output logic o_file_we,
  output logic [6:0] o_file_addr,
  output logic [7:0] o_file_wdata,
  // Accumulator and status.
  output logic [7:0] o_accumulator,
  output logic o_zero_flag,
  output logic o_timeout_flag_n,
  output logic o_powerdown_flag_n,
  output logic [15:0] o_watchdog_counter,
  // Cycle in which a discarded word is replaced by a no-operation.
  output logic o_busy
);
  import cise_pkg::*;

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  cise_dec_if dec_if ();  // Decoded fields of the current word.

  cise_decode u_decode (
    .i_instr(i_instr),
    .dec(dec_if.dec)
  );

  cise_state_t state_r;  // Run or flush of the discarded word.
  logic [14:0] pc_r;  // Program counter.
  logic [7:0] acc_r;  // Working accumulator.
  logic zero_r;  // Zero flag.
  logic to_n_r;  // Active-low timeout flag.
  logic pwrdn_n_r;  // Active-low power-down flag.
  logic [15:0] wdt_r;  // Watchdog counter.
  logic [7:0] pre_r;  // Watchdog prescaler.
  logic exec;  // A word is taken and executes this cycle.
  logic [7:0] comp;  // Complemented file value.

  // Words arriving during a flush cycle are the discarded ones.
  assign exec = i_instr_valid && (state_r == CISE_ST_RUN);
  assign comp = ~i_file_rdata;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // Two-cycle instructions spend their second cycle in flush, during
  // which the fetched word is dropped and nothing executes.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= CISE_ST_RUN;
    end else begin
      case (state_r)
        CISE_ST_RUN: begin
          if (exec) begin
            if (dec_if.op == CISE_OP_BTSS && i_file_rdata[dec_if.bsel]) begin
              state_r <= CISE_ST_FLUSH;
            end else if (dec_if.op == CISE_OP_CALL || dec_if.op == CISE_OP_ACC_CALL) begin
              state_r <= CISE_ST_FLUSH;
            end
          end
        end
        CISE_ST_FLUSH: begin
          // The flush occupies exactly one valid word slot.
          if (i_instr_valid) begin
            state_r <= CISE_ST_RUN;
          end
        end
        default: begin
          state_r <= CISE_ST_RUN;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Program counter and stack push
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pc_r <= `CISE_PC_RST;
      o_stack_push <= 1'b0;
      o_return_stack_top <= `CISE_PC_RST;
    end else begin
      o_stack_push <= 1'b0;
      if (exec && dec_if.op == CISE_OP_CALL) begin
        o_stack_push <= 1'b1;
        o_return_stack_top <= pc_r + 15'h0001;
        pc_r <= {i_program_counter_latch_high[6:3], dec_if.kimm};
      end else if (exec && dec_if.op == CISE_OP_ACC_CALL) begin
        o_stack_push <= 1'b1;
        o_return_stack_top <= pc_r + 15'h0001;
        pc_r <= {i_program_counter_latch_high, acc_r};
      end else if (i_instr_valid) begin
        // Normal words and flushed no-operations both advance by one.
        pc_r <= pc_r + 15'h0001;
      end
    end
  end

  // --------------------------------------------------------------
  // File register write port
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_file_we <= 1'b0;
      o_file_addr <= 7'h00;
      o_file_wdata <= `CISE_ZERO8;
    end else begin
      o_file_we <= 1'b0;
      o_file_addr <= dec_if.faddr;
      if (exec && dec_if.op == CISE_OP_FILE_CLR) begin
        o_file_we <= 1'b1;
        o_file_wdata <= `CISE_ZERO8;
      end else if (exec && dec_if.op == CISE_OP_FILE_CPL && dec_if.dsel) begin
        o_file_we <= 1'b1;
        o_file_wdata <= comp;
      end
    end
  end

  // --------------------------------------------------------------
  // Accumulator and zero flag
  // --------------------------------------------------------------
  // Skip and both calls fall through every branch, so flags hold.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      acc_r <= `CISE_ZERO8;
      zero_r <= 1'b0;
    end else if (exec) begin
      case (dec_if.op)
        CISE_OP_FILE_CLR: begin
          zero_r <= 1'b1;
        end
        CISE_OP_ACC_CLR: begin
          acc_r <= `CISE_ZERO8;
          zero_r <= 1'b1;
        end
        CISE_OP_FILE_CPL: begin
          if (!dec_if.dsel) begin
            acc_r <= comp;
          end
          zero_r <= (comp == `CISE_ZERO8);
        end
        default: begin
          zero_r <= zero_r;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Watchdog and its flags
  // --------------------------------------------------------------
  // The prescaler wraps into the counter; a clear wins over a tick.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wdt_r <= `CISE_WDT_RST;
      pre_r <= `CISE_PRE_RST;
      to_n_r <= 1'b1;
      pwrdn_n_r <= 1'b1;
    end else if (exec && dec_if.op == CISE_OP_WDOG_CLR) begin
      wdt_r <= `CISE_WDT_RST;
      pre_r <= `CISE_PRE_RST;
      to_n_r <= 1'b1;
      pwrdn_n_r <= 1'b1;
    end else if (i_wdt_tick) begin
      pre_r <= pre_r + 8'h01;
      if (pre_r == 8'hff) begin
        wdt_r <= wdt_r + 16'h0001;
        // Counter overflow marks a timeout; the flag stays until cleared.
        if (wdt_r == 16'hffff) begin
          to_n_r <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign o_program_counter = pc_r;
  assign o_accumulator = acc_r;
  assign o_zero_flag = zero_r;
  assign o_timeout_flag_n = to_n_r;
  assign o_powerdown_flag_n = pwrdn_n_r;
  assign o_watchdog_counter = wdt_r;
  assign o_busy = (state_r == CISE_ST_FLUSH);
endmodule

// ---- sim/cise_core_sva.sv ----
// Assertion checker bound to the ports of the execution block.
module cise_core_sva (
  // Clock, reset and stimulus.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic [6:0] i_program_counter_latch_high,
  input wire logic i_wdt_tick,
  // Results.
  input wire logic [14:0] o_program_counter,
  input wire logic o_stack_push,
  input wire logic [14:0] o_return_stack_top,
  input wire logic o_file_we,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_accumulator,
  input wire logic o_zero_flag,
  input wire logic o_timeout_flag_n,
  input wire logic o_powerdown_flag_n,
  input wire logic [15:0] o_watchdog_counter,
  input wire logic o_busy
);
  // A word executes only outside the discarded slot.
  logic go;
  assign go = i_instr_valid && !o_busy;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  skip_set_a: assert property (go && i_instr[13:10] == 4'hb
    && i_file_rdata[i_instr[9:7]] |=> o_busy) else $error("skip not taken");
  skip_clear_a: assert property (go && i_instr[13:10] == 4'hb
    && !i_file_rdata[i_instr[9:7]] |=> !o_busy) else $error("skip wrongly taken");
  call_imm_a: assert property (go && i_instr[13:11] == 3'h4 |=> o_stack_push
    && o_program_counter == {$past(i_program_counter_latch_high[6:3]), $past(i_instr[10:0])}
    && o_return_stack_top == $past(o_program_counter) + 15'h1) else $error("call bad");
  call_acc_a: assert property (go && i_instr == 14'h000a |=> o_stack_push
    && o_program_counter == {$past(i_program_counter_latch_high), $past(o_accumulator)})
    else $error("accumulator call bad");
  clear_file_a: assert property (go && i_instr[13:7] == 7'h03 |=> o_file_we
    && o_file_wdata == 8'h00 && o_zero_flag) else $error("clear file bad");
  clear_acc_a: assert property (go && i_instr[13:2] == 12'h040 |=>
    o_accumulator == 8'h00 && o_zero_flag) else $error("clear accumulator bad");
  clear_wdog_a: assert property (go && i_instr == 14'h0064 |=>
    o_watchdog_counter == 16'h0000 && o_timeout_flag_n && o_powerdown_flag_n)
    else $error("clear watchdog bad");
  comp_acc_a: assert property (go && i_instr[13:7] == 7'h12 |=>
    o_accumulator == ~$past(i_file_rdata) && o_zero_flag == ($past(i_file_rdata) == 8'hff))
    else $error("complement to accumulator bad");
  comp_file_a: assert property (go && i_instr[13:7] == 7'h13 |=> o_file_we
    && o_file_wdata == ~$past(i_file_rdata)) else $error("complement to file bad");
  flags_kept_a: assert property (go && (i_instr[13:10] == 4'hb || i_instr[13:11] == 3'h4
    || i_instr == 14'h000a) |=> $stable(o_zero_flag)
    && ($stable(o_timeout_flag_n) || $past(i_wdt_tick))
    && $stable(o_powerdown_flag_n)) else $error("flags changed");
endmodule
bind cise_core cise_core_sva sva_i (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_instr_valid(i_instr_valid),
  .i_instr(i_instr),
  .i_file_rdata(i_file_rdata),
  .i_program_counter_latch_high(i_program_counter_latch_high),
  .i_wdt_tick(i_wdt_tick),
  .o_program_counter(o_program_counter),
  .o_stack_push(o_stack_push),
  .o_return_stack_top(o_return_stack_top),
  .o_file_we(o_file_we),
  .o_file_wdata(o_file_wdata),
  .o_accumulator(o_accumulator),
  .o_zero_flag(o_zero_flag),
  .o_timeout_flag_n(o_timeout_flag_n),
  .o_powerdown_flag_n(o_powerdown_flag_n),
  .o_watchdog_counter(o_watchdog_counter),
  .o_busy(o_busy)
);

// ---- sim/tb.sv ----
// Self-checking bench for the instruction subset execution block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_rst_n = 0, i_instr_valid = 0, i_wdt_tick = 0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0] i_file_rdata = 8'h00;
  logic [6:0] i_program_counter_latch_high = 7'h5a;
  logic [14:0] o_program_counter, o_return_stack_top, pc0;
  logic o_stack_push, o_file_we, o_zero_flag, o_timeout_flag_n, o_powerdown_flag_n, o_busy;
  logic [6:0] o_file_addr;
  logic [7:0] o_file_wdata, o_accumulator;
  logic [15:0] o_watchdog_counter;
  int fails = 0, n_compared = 0;
  cise_core dut (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_file_rdata(i_file_rdata),
    .i_program_counter_latch_high(i_program_counter_latch_high),
    .i_wdt_tick(i_wdt_tick),
    .o_program_counter(o_program_counter),
    .o_stack_push(o_stack_push),
    .o_return_stack_top(o_return_stack_top),
    .o_file_we(o_file_we),
    .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata),
    .o_accumulator(o_accumulator),
    .o_zero_flag(o_zero_flag),
    .o_timeout_flag_n(o_timeout_flag_n),
    .o_powerdown_flag_n(o_powerdown_flag_n),
    .o_watchdog_counter(o_watchdog_counter),
    .o_busy(o_busy)
  );
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Compare one observed value with its expectation.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Present one word across one rising edge; results are settled on return.
  // Valid stays high until the next word or an explicit idle, so that it is
  // never written twice at one falling edge.
  task automatic step(input logic [13:0] w, input logic [7:0] f);
    pc0 = o_program_counter;
    i_instr_valid = 1'b1;
    i_instr = w;
    i_file_rdata = f;
    @(negedge i_ref_clk);
  endtask
  // Set bit discards the next word; bit 7 clear lets it run.
  task automatic t_skip;
    step(14'h0910, 8'h00);
    chk(o_accumulator, 16'h00ff);
    step(14'h2d85, 8'h08);
    chk(o_busy, 16'h0001);
    chk(o_program_counter, pc0 + 15'h1);
    step(14'h0100, 8'h00);
    chk(o_accumulator, 16'h00ff);
    chk(o_zero_flag, 16'h0000);
    step(14'h2f85, 8'h7f);
    chk(o_busy, 16'h0000);
    step(14'h0103, 8'h00);
    chk(o_accumulator, 16'h0000);
    chk(o_zero_flag, 16'h0001);
    $display("done skip");
  endtask
  // Immediate call at the top of the range, then its flushed slot.
  task automatic t_call;
    step(14'h27ff, 8'h00);
    chk(o_program_counter, 16'h5fff);
    chk(o_return_stack_top, pc0 + 15'h1);
    chk(o_stack_push, 16'h0001);
    chk(o_zero_flag, 16'h0001);
    step(14'h0100, 8'h00);
    chk(o_program_counter, 16'h6000);
    chk(o_stack_push, 16'h0000);
    $display("done call");
  endtask
  // Accumulator call after loading the accumulator.
  task automatic t_acc_call;
    step(14'h0910, 8'h3c);
    step(14'h000a, 8'h00);
    chk(o_program_counter, {1'b0, 7'h5a, 8'hc3});
    chk(o_return_stack_top, pc0 + 15'h1);
    chk(o_stack_push, 16'h0001);
    chk(o_zero_flag, 16'h0000);
    step(14'h0000, 8'h00);
    chk(o_program_counter, 16'h5ac4);
    chk(o_busy, 16'h0000);
    $display("done accumulator call");
  endtask
  // File clear and complement to both destinations.
  task automatic t_file;
    step(14'h01a5, 8'h77);
    chk({o_file_we, o_file_addr, o_file_wdata}, 16'ha500);
    chk(o_zero_flag, 16'h0001);
    step(14'h0991, 8'h0f);
    chk({o_file_we, o_file_addr, o_file_wdata}, 16'h91f0);
    chk({o_zero_flag, o_accumulator}, 16'h00c3);
    step(14'h0911, 8'hff);
    chk({o_file_we, o_zero_flag, o_accumulator}, 16'h0100);
    $display("done file");
  endtask
  // Watchdog advances on ticks and is cleared even with a tick present.
  task automatic t_wdt;
    i_instr_valid = 1'b0;
    i_wdt_tick = 1'b1;
    repeat (600) @(negedge i_ref_clk);
    chk(o_watchdog_counter, 16'h0002);
    step(14'h0064, 8'h00);
    i_instr_valid = 1'b0;
    chk(o_watchdog_counter, 16'h0000);
    chk({o_timeout_flag_n, o_powerdown_flag_n}, 16'h0003);
    // A cleared prescaler needs a full 256 ticks before the counter moves.
    repeat (255) @(negedge i_ref_clk);
    chk(o_watchdog_counter, 16'h0000);
    @(negedge i_ref_clk);
    chk(o_watchdog_counter, 16'h0001);
    i_wdt_tick = 1'b0;
    $display("done watchdog");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    chk(o_program_counter, 16'h0000);
    t_skip;
    t_call;
    t_acc_call;
    t_file;
    t_wdt;
    give_verdict;
  end
  // The run needs under 900 cycles; cut a hang well beyond that.
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule
